// [verilog/tpc_pkg.sv]
package tpc_pkg;

	// Register byte offsets on the APB window
	localparam logic [7:0] OFF_CTRL   = 8'h00;
	localparam logic [7:0] OFF_COUNT  = 8'h04;
	localparam logic [7:0] OFF_RELOAD = 8'h08;
	localparam logic [7:0] OFF_MATCH  = 8'h0C;
	localparam logic [7:0] OFF_STATUS = 8'h10;
	localparam logic [7:0] OFF_MASK   = 8'h14;

	// Register select codes; SEL_NONE marks an unmapped address
	localparam logic [2:0] SEL_CTRL   = 3'h0;
	localparam logic [2:0] SEL_COUNT  = 3'h1;
	localparam logic [2:0] SEL_RELOAD = 3'h2;
	localparam logic [2:0] SEL_MATCH  = 3'h3;
	localparam logic [2:0] SEL_STATUS = 3'h4;
	localparam logic [2:0] SEL_MASK   = 3'h5;
	localparam logic [2:0] SEL_NONE   = 3'h7;

	// Status and mask bit positions
	localparam int unsigned ST_RELOAD  = 0;
	localparam int unsigned ST_CAPTURE = 1;
	localparam int unsigned ST_MATCH   = 2;

	// Reset and restart values
	localparam logic [7:0]  CTRL_RST     = 8'h00;
	localparam logic [15:0] COUNT_RST    = 16'h0000;
	localparam logic [15:0] RELOAD_RST   = 16'hFFFF;
	localparam logic [15:0] MATCH_RST    = 16'h0000;
	localparam logic [2:0]  STATUS_RST   = 3'h0;
	localparam logic [2:0]  MASK_RST     = 3'h0;
	localparam logic [15:0] COUNT_RESTART = 16'h0001;
	localparam logic [15:0] COUNT_TOP    = 16'hFFFF;
	localparam logic [15:0] COUNT_WRAP   = 16'h0000;

	// Operating modes, every code legal
	typedef enum logic [1:0] {
		TPC_MODE_COUNTER = 2'b00,
		TPC_MODE_PWM     = 2'b01,
		TPC_MODE_CAPTURE = 2'b10,
		TPC_MODE_COMPARE = 2'b11
	} tpc_mode_e;

	// Control register layout, bit 7 down to bit 0
	typedef struct packed {
		logic [2:0] prescale;
		logic       edge_fall;
		logic       output_polarity_select;
		tpc_mode_e  mode;
		logic       enable;
	} tpc_ctrl_s;

	// APB request and answer bundles
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} tpc_apb_req_s;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} tpc_apb_rsp_s;

endpackage : tpc_pkg

// [verilog/tpc_prescaler.sv]
`timescale 1ns/1ps
module tpc_prescaler (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       ce,
	input  wire logic       run,
	input  wire logic [2:0] prescale,
	output logic            tick
);
	typedef struct packed {
		logic [6:0] cnt;
	} tpc_pre_state_s;

	tpc_pre_state_s q;
	tpc_pre_state_s d;
	logic [6:0]     limit;

	// Divide by two to the power of the prescale field
	assign limit = 7'(8'(8'h01 << prescale) - 8'h01);
	assign tick  = run && (q.cnt == limit);

	// Divider restarts whenever the timer is stopped
	always_comb
	begin
		d = q;
		if (!run || tick)
			d.cnt = 7'h00;
		else
			d.cnt = q.cnt + 7'h01;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			q <= '0;
		else if (ce)
			q <= d;
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn || !ce);

	chk_tick_spacing: assert property (tick && prescale == 3'h1 && run |=> !tick)
		else $error("prescaler ticked twice in a row at divide by two");

endmodule : tpc_prescaler

// [verilog/tpc_edge_detect.sv]
`timescale 1ns/1ps
module tpc_edge_detect (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic ce,
	input  wire logic pin,
	input  wire logic fall_sel,
	output logic      edge_seen
);
	typedef struct packed {
		logic prev;
	} tpc_edge_state_s;

	tpc_edge_state_s q;
	tpc_edge_state_s d;

	// Pin is synchronous, so the previous sample is all we keep
	assign edge_seen = fall_sel ? (q.prev && !pin) : (!q.prev && pin);

	always_comb
	begin
		d      = q;
		d.prev = pin;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			q <= '0;
		else if (ce)
			q <= d;
	end

endmodule : tpc_edge_detect

// [verilog/tpc_timer.sv]
// Summary of operation
// - PWM mode counts up from the system clock toward the 16-bit reload value.
// - Output level inverts when the count equals the match value.
// - PWM counts on to reload, interrupts, restarts at 0001H and keeps running.
// - Polarity one: output starts high, falls at match, returns high at reload.
// - Polarity zero: output starts low, rises at match, returns low at reload.
// - PWM mode counts system clock ticks, never the timer input pin.
// - Software start count only shapes the first period; later periods start at 0001H.
// - Counter mode steps once per qualifying timer input transition.
// - Capture edge is selectable as rising or falling.
// - Capture copies the count into the match register and interrupts.
// - Capture mode also counts to reload and interrupts there.
// - Compare mode toggles and interrupts at reload, rolls FFFFH to 0000H without restart.
`timescale 1ns/1ps
module tpc_timer (
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic                 ce,
	input  wire tpc_pkg::tpc_apb_req_s apb_req,
	output tpc_pkg::tpc_apb_rsp_s     apb_rsp,
	input  wire logic                 timer_in,
	output logic                      timer_out,
	output logic                      irq_pulse,
	output logic                      irq
);
	typedef struct packed {
		tpc_pkg::tpc_ctrl_s ctrl;
		logic [15:0]        count;
		logic [15:0]        reload;
		logic [15:0]        match;
		logic [2:0]         status;
		logic [2:0]         mask;
		logic               tout;
		logic               irq_pulse;
		logic [31:0]        prdata;
	} tpc_state_s;

	tpc_state_s q;
	tpc_state_s d;
	logic       tick;
	logic       in_edge;
	logic       adv;
	logic       capture;
	logic [2:0] sel;
	logic       setup_rd;
	logic       wr;
	logic       rd_done;
	logic       at_reload;
	logic       at_match;
	logic [2:0] ev;

	// Address decode, shared by the read path and the write path
	function automatic logic [2:0] tpc_sel(input logic [7:0] addr);
		logic [2:0] s;
		unique case (addr)
			tpc_pkg::OFF_CTRL:   s = tpc_pkg::SEL_CTRL;
			tpc_pkg::OFF_COUNT:  s = tpc_pkg::SEL_COUNT;
			tpc_pkg::OFF_RELOAD: s = tpc_pkg::SEL_RELOAD;
			tpc_pkg::OFF_MATCH:  s = tpc_pkg::SEL_MATCH;
			tpc_pkg::OFF_STATUS: s = tpc_pkg::SEL_STATUS;
			tpc_pkg::OFF_MASK:   s = tpc_pkg::SEL_MASK;
			default:             s = tpc_pkg::SEL_NONE;
		endcase
		return s;
	endfunction : tpc_sel

	tpc_prescaler u_pre (
		.pclk     (pclk),
		.presetn  (presetn),
		.ce       (ce),
		.run      (q.ctrl.enable),
		.prescale (q.ctrl.prescale),
		.tick     (tick)
	);

	tpc_edge_detect u_edge (
		.pclk      (pclk),
		.presetn   (presetn),
		.ce        (ce),
		.pin       (timer_in),
		.fall_sel  (q.ctrl.edge_fall),
		.edge_seen (in_edge)
	);

	// Bus phases; the clock enable stalls the bus so no write is lost while frozen
	assign sel      = tpc_sel(apb_req.paddr);
	assign setup_rd = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
	assign wr       = ce && apb_req.psel && apb_req.penable && apb_req.pwrite;
	assign rd_done  = ce && apb_req.psel && apb_req.penable && !apb_req.pwrite;

	// Counter mode follows pin transitions, every other mode the prescaled clock
	assign adv       = q.ctrl.enable && ((q.ctrl.mode == tpc_pkg::TPC_MODE_COUNTER) ? in_edge : tick);
	assign capture   = q.ctrl.enable && (q.ctrl.mode == tpc_pkg::TPC_MODE_CAPTURE) && in_edge;
	assign at_reload = (q.count == q.reload);
	assign at_match  = (q.count == q.match);

	// Answer outputs; read data was latched in the setup cycle
	assign apb_rsp.pready  = ce;
	assign apb_rsp.pslverr = apb_req.psel && apb_req.penable && (sel == tpc_pkg::SEL_NONE);
	assign apb_rsp.prdata  = q.prdata;
	assign timer_out       = q.tout;
	assign irq_pulse       = q.irq_pulse;
	assign irq             = |(q.status & q.mask);

	// Next-state logic: counting, events, then software writes on top
	always_comb
	begin
		d           = q;
		d.irq_pulse = 1'b0;
		ev          = 3'h0;

		if (setup_rd)
		begin
			unique case (sel)
				tpc_pkg::SEL_CTRL:   d.prdata = {24'h000000, q.ctrl};
				tpc_pkg::SEL_COUNT:  d.prdata = {16'h0000, q.count};
				tpc_pkg::SEL_RELOAD: d.prdata = {16'h0000, q.reload};
				tpc_pkg::SEL_MATCH:  d.prdata = {16'h0000, q.match};
				tpc_pkg::SEL_STATUS: d.prdata = {29'h00000000, q.status};
				tpc_pkg::SEL_MASK:   d.prdata = {29'h00000000, q.mask};
				default:             d.prdata = 32'h00000000;
			endcase
		end

		if (!q.ctrl.enable)
			d.tout = q.ctrl.output_polarity_select;
		else if (adv)
		begin
			unique case (q.ctrl.mode)
				tpc_pkg::TPC_MODE_COMPARE:
				begin
					// No restart here: the count simply wraps past the top
					d.count = q.count + 16'h0001;
					if (at_reload)
					begin
						d.tout         = !q.tout;
						ev[tpc_pkg::ST_RELOAD] = 1'b1;
					end
				end
				tpc_pkg::TPC_MODE_PWM:
				begin
					if (at_reload)
					begin
						d.count        = tpc_pkg::COUNT_RESTART;
						d.tout         = q.ctrl.output_polarity_select;
						ev[tpc_pkg::ST_RELOAD] = 1'b1;
					end
					else
					begin
						d.count = q.count + 16'h0001;
						if (at_match)
						begin
							d.tout        = !q.tout;
							ev[tpc_pkg::ST_MATCH] = 1'b1;
						end
					end
				end
				tpc_pkg::TPC_MODE_COUNTER, tpc_pkg::TPC_MODE_CAPTURE:
				begin
					if (at_reload)
					begin
						d.count        = tpc_pkg::COUNT_RESTART;
						ev[tpc_pkg::ST_RELOAD] = 1'b1;
					end
					else
						d.count = q.count + 16'h0001;
				end
			endcase
		end

		// Capture latches the count as it stood before this cycle's step
		if (capture)
		begin
			d.match                 = q.count;
			ev[tpc_pkg::ST_CAPTURE] = 1'b1;
		end

		// Reading status clears only the bits the read returned; an event that
		// lands in the setup cycle missed the snapshot and must stay pending
		if (rd_done && sel == tpc_pkg::SEL_STATUS)
			d.status = (q.status & ~q.prdata[2:0]) | ev;
		else
			d.status = q.status | ev;
		d.irq_pulse = q.ctrl.enable && (|ev);

		// Software writes take effect last so a reprogram wins over counting
		if (wr)
		begin
			unique case (sel)
				tpc_pkg::SEL_CTRL:   d.ctrl   = tpc_pkg::tpc_ctrl_s'(apb_req.pwdata[7:0]);
				tpc_pkg::SEL_COUNT:  d.count  = apb_req.pwdata[15:0];
				tpc_pkg::SEL_RELOAD: d.reload = apb_req.pwdata[15:0];
				tpc_pkg::SEL_MATCH:  d.match  = apb_req.pwdata[15:0];
				tpc_pkg::SEL_MASK:   d.mask   = apb_req.pwdata[2:0];
				default:             d.mask   = q.mask;
			endcase
		end
	end

	// Single state register; the clock enable freezes everything
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			q.ctrl      <= tpc_pkg::tpc_ctrl_s'(tpc_pkg::CTRL_RST);
			q.count     <= tpc_pkg::COUNT_RST;
			q.reload    <= tpc_pkg::RELOAD_RST;
			q.match     <= tpc_pkg::MATCH_RST;
			q.status    <= tpc_pkg::STATUS_RST;
			q.mask      <= tpc_pkg::MASK_RST;
			q.tout      <= 1'b0;
			q.irq_pulse <= 1'b0;
			q.prdata    <= 32'h00000000;
		end
		else if (ce)
			q <= d;
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Helpers: no software write lands on the watched register
	logic no_wr;
	assign no_wr = !wr;

	sequence seq_pwm_reload;
		ce && no_wr && adv && q.ctrl.mode == tpc_pkg::TPC_MODE_PWM && at_reload;
	endsequence

	sequence seq_pwm_match;
		ce && no_wr && adv && q.ctrl.mode == tpc_pkg::TPC_MODE_PWM && !at_reload && at_match;
	endsequence

	sequence seq_pwm_step;
		ce && no_wr && adv && q.ctrl.mode == tpc_pkg::TPC_MODE_PWM && !at_reload;
	endsequence

	sequence seq_capture_reload;
		ce && no_wr && adv && q.ctrl.mode == tpc_pkg::TPC_MODE_CAPTURE && at_reload;
	endsequence

	chk_pwm_restart: assert property (seq_pwm_reload |=> q.count == 16'h0001)
		else $error("pwm count did not restart at 0001");
	chk_pwm_polarity: assert property (seq_pwm_reload |=> q.tout == q.ctrl.output_polarity_select)
		else $error("pwm output not back at polarity level after reload");
	chk_pwm_toggle: assert property (seq_pwm_match |=> q.tout != $past(q.tout))
		else $error("pwm output did not invert at match");
	chk_reload_irq: assert property (ce && adv && at_reload |=> q.irq_pulse ##1 (!ce || !q.irq_pulse))
		else $error("reload did not give a one-cycle interrupt pulse");
	chk_counter_step: assert property (ce && no_wr && adv && !at_reload
		&& q.ctrl.mode == tpc_pkg::TPC_MODE_COUNTER |=> q.count == $past(q.count) + 16'h0001)
		else $error("counter mode missed an input transition");
	chk_capture_store: assert property (ce && no_wr && capture |=> q.match == $past(q.count)
		&& q.status[tpc_pkg::ST_CAPTURE])
		else $error("capture did not store the count");
	chk_compare_wrap: assert property (ce && no_wr && adv && q.ctrl.mode == tpc_pkg::TPC_MODE_COMPARE
		&& q.count == 16'hFFFF |=> q.count == 16'h0000)
		else $error("compare mode did not roll over to zero");
	chk_pwm_step: assert property (seq_pwm_step |=> q.count == $past(q.count) + 16'h0001)
		else $error("pwm count did not step toward reload");
	chk_capture_reload: assert property (seq_capture_reload |=> q.count == tpc_pkg::COUNT_RESTART
		&& q.status[tpc_pkg::ST_RELOAD])
		else $error("capture mode reload did not restart and flag");

	// A stopped timer keeps the start count software left for the first period
	chk_idle_count: assert property (ce && !q.ctrl.enable && no_wr |=> $stable(q.count))
		else $error("count moved while the timer was stopped");
	// Pending events only leave status through a status read
	chk_status_sticky: assert property (ce && !(rd_done && sel == tpc_pkg::SEL_STATUS)
		|=> (q.status | $past(q.status)) == q.status)
		else $error("status bit dropped without a status read");
	chk_irq_enabled: assert property ($rose(q.irq_pulse) |-> $past(q.ctrl.enable))
		else $error("interrupt pulse while timer disabled");
	chk_idle_level: assert property (ce && !q.ctrl.enable && no_wr |=> q.tout == q.ctrl.output_polarity_select)
		else $error("idle output not at polarity level");

endmodule : tpc_timer

// [dv/tpc_pin_model.sv]
`timescale 1ns/1ps
module tpc_pin_model (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic run,
	input  wire logic slow,
	output logic      timer_in
);
	logic [1:0] gap;

	// Pin source: edges every cycle, or every fourth cycle when slow, so both
	// quick and sparse traffic reach the edge detector
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			gap      <= 2'h0;
			timer_in <= 1'b0;
		end
		else if (run)
		begin
			gap <= gap + 2'h1;
			if (!slow || gap == 2'h3)
				timer_in <= ~timer_in;
		end
	end
endmodule : tpc_pin_model

// [dv/testbench.sv]
`timescale 1ns/1ps
module testbench;
	logic                  pclk, presetn, ce, run, slow, timer_in, timer_out, irq_pulse, irq;
	logic                  pol, out, pulse, lvl, err, prev_in;
	tpc_pkg::tpc_apb_req_s req;
	tpc_pkg::tpc_apb_rsp_s rsp;
	logic [31:0]           rd;
	int                    error_cnt, comparisons, rises, cnt, rel, mat, st, msk, n, start, base;
	integer                seed;
	logic [7:0]            offs [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h20};
	logic [31:0]           rsts [7] = '{32'h0, 32'h0, 32'hFFFF, 32'h0, 32'h0, 32'h0, 32'h0};

	tpc_timer i_tpc_timer (.pclk(pclk), .presetn(presetn), .ce(ce), .apb_req(req), .apb_rsp(rsp),
		.timer_in(timer_in), .timer_out(timer_out), .irq_pulse(irq_pulse), .irq(irq));
	tpc_pin_model i_tpc_pin_model (.pclk(pclk), .presetn(presetn), .run(run), .slow(slow),
		.timer_in(timer_in));

	// Bench clock, 25 ns period
	initial
	begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	// Reference tally of rising pin edges for counter mode
	always @(posedge pclk)
	begin
		prev_in <= timer_in;
		if (timer_in === 1'b1 && prev_in === 1'b0)
			rises <= rises + 1;
	end

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	// One transfer; the request stands until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge pclk);
		req.penable <= 1'b1;
		do
			@(posedge pclk);
		while (rsp.pready !== 1'b1);
		rd = rsp.prdata;
		err = rsp.pslverr;
		req <= '0;
	endtask : apb

	// Reference timer: one edge of the enabled timer in a clocked mode
	task automatic step(input logic [1:0] mode, input logic [2:0] p);
		pulse = 1'b0;
		n++;
		if (n % (1 << p) != 0)
			return;
		if (cnt == rel)
		begin
			pulse = 1'b1;
			st |= 1;
			out = (mode == tpc_pkg::TPC_MODE_PWM) ? pol : ~out;
			cnt = (mode == tpc_pkg::TPC_MODE_PWM) ? 1 : (cnt + 1) & 32'hFFFF;
		end
		else
		begin
			if (mode == tpc_pkg::TPC_MODE_PWM && cnt == mat)
			begin
				pulse = 1'b1;
				st |= 4;
				out = ~out;
			end
			cnt = (cnt + 1) & 32'hFFFF;
		end
	endtask : step

	// Program while disabled, enable last, then follow the reference edge by edge
	task automatic run_mode(input logic [1:0] mode, input logic [2:0] p, input int cycles);
		apb(1, 8'h00, {p, 1'b0, pol, mode, 1'b0});
		apb(0, 8'h10, 32'h0);
		apb(1, 8'h14, msk);
		apb(1, 8'h08, rel);
		apb(1, 8'h0C, mat);
		apb(1, 8'h04, start);
		apb(1, 8'h00, {p, 1'b0, pol, mode, 1'b1});
		cnt = start;
		n = 0;
		out = pol;
		st = 0;
		repeat (cycles)
		begin
			@(posedge pclk);
			step(mode, p);
			#1;
			chk("timer_out", out, timer_out);
			chk("irq", (st & msk) != 0, irq);
			chk("irq_pulse", pulse, irq_pulse);
		end
		apb(1, 8'h00, {p, 1'b0, pol, mode, 1'b0});
		repeat (3) @(posedge pclk);
		chk("idle_out", pol, timer_out);
		chk("idle_pulse", 1'b0, irq_pulse);
		apb(0, 8'h10, 32'h0);
		chk("status", st, rd);
		#1;
		chk("irq_clear", 1'b0, irq);
		$display("test mode %0d done", mode);
	endtask : run_mode

	task automatic conclude;
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : conclude

	// Main sequence
	initial
	begin
		seed = 32'hB6D1;
		presetn = 1'b0;
		ce = 1'b1;
		run = 1'b0;
		slow = 1'b0;
		req = '0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		// Reset values, an ignored status write, and an unmapped address last
		apb(1, 8'h10, 32'h7);
		for (int i = 0; i < 7; i++)
		begin
			apb(0, offs[i], 32'h0);
			chk("reset_value", rsts[i], rd);
			chk("slave_error", i == 6, err);
		end
		$display("test registers done");
		// Both polarities, random match; the toggling pin must not be counted
		run <= 1'b1;
		for (int k = 0; k < 2; k++)
		begin
			pol = k[0];
			rel = 8;
			mat = 2 + $unsigned($random(seed)) % 5;
			start = 1 + $unsigned($random(seed)) % (mat - 1);
			msk = 1 << (2 * k); // Reload interrupt first, then the match interrupt
			run_mode(tpc_pkg::TPC_MODE_PWM, 3'h0, 30);
		end
		run <= 1'b0;
		// Compare mode through the top of the count, masked, divided by two
		pol = 1'b0;
		rel = 32'hFFFC;
		mat = 0;
		start = 32'hFFFA;
		msk = 0;
		run_mode(tpc_pkg::TPC_MODE_COMPARE, 3'h1, 24);
		// Counter mode from a random start
		start = $unsigned($random(seed)) % 32'h7000 + 32'h10;
		apb(1, 8'h00, {3'h0, 1'b0, 1'b0, tpc_pkg::TPC_MODE_COUNTER, 1'b0});
		apb(1, 8'h04, start);
		apb(1, 8'h00, {3'h0, 1'b0, 1'b0, tpc_pkg::TPC_MODE_COUNTER, 1'b1});
		base = rises;
		run <= 1'b1;
		repeat (21) @(posedge pclk);
		run <= 1'b0;
		repeat (4) @(posedge pclk);
		apb(0, 8'h04, 32'h0);
		chk("count", start + rises - base, rd);
		$display("test counter done");
		// Capture on falling edges only, match cleared before each edge
		apb(1, 8'h00, {3'h0, 1'b1, 1'b0, tpc_pkg::TPC_MODE_CAPTURE, 1'b0});
		apb(1, 8'h00, {3'h0, 1'b1, 1'b0, tpc_pkg::TPC_MODE_CAPTURE, 1'b1});
		for (int k = 0; k < 3; k++)
		begin
			apb(1, 8'h0C, 32'h0);
			lvl = timer_in;
			slow <= 1'b1;
			run <= 1'b1;
			repeat (4) @(posedge pclk);
			run <= 1'b0;
			repeat (3) @(posedge pclk);
			apb(0, 8'h10, 32'h0);
			chk("capture_flag", lvl, rd[1]);
			apb(0, 8'h0C, 32'h0);
			chk("capture_taken", lvl, rd != 0);
		end
		// Quiet pin: only the reload interrupts, so the cleared match stays clear
		apb(1, 8'h00, {3'h0, 1'b1, 1'b0, tpc_pkg::TPC_MODE_CAPTURE, 1'b0});
		apb(1, 8'h0C, 32'h0);
		apb(1, 8'h04, 32'h1);
		apb(1, 8'h08, 32'h20);
		apb(0, 8'h10, 32'h0);
		apb(1, 8'h00, {3'h0, 1'b1, 1'b0, tpc_pkg::TPC_MODE_CAPTURE, 1'b1});
		repeat (40) @(posedge pclk);
		apb(0, 8'h10, 32'h0);
		chk("reload_flag", 32'h1, rd);
		apb(0, 8'h0C, 32'h0);
		chk("reload_match", 32'h0, rd);
		$display("test capture done");
		conclude;
	end

	// Watchdog well beyond the few hundred cycles the tests need
	initial
	begin
		repeat (4000) @(posedge pclk);
		error_cnt++;
		conclude;
	end
endmodule : testbench
